// File: logic/cpec_core.sv
// Functional notes
// R01 - User qualifier: privilege 2, both levels clear; exception qualifier: exception set, error clear.
// R02 - Counter 0 codes 0-3 and 8: cycles, branches, jr, jr rs31, predicted branches.
// R03 - Counter 0: code 4 instruction cache misses, code 9 accepted memory reads.
// R04 - Counter 0: codes 5, 6, 7 issues to first ALU, memory unit, first FP ALU.
// R05 - Counter 0: codes a, b, c fixed-point, reorder, coprocessor queue full.
// R06 - Counter 0: code d refill exceptions 34/35, e code 0, f code 63.
// R07 - Counter 1 codes 0-3 and 8: commits, branch, jr, jr rs31, history mispredicts.
// R08 - Counter 1: code 4 data cache misses, 7 uncached accesses, 9 memory writes.
// R09 - Counter 1: code 5 second ALU issues, code 6 second FP ALU issues.
// R10 - Counter 1: code a floating-point queue full, code b branch queue full.
// R11 - Counter 1: code c instruction TLB misses, code d any exception.
// R12 - Counter 1: code e load speculation misses, code f queue load forwarding.
// R13 - Each counter is 64 bits, read/write, increments independently on qualified events.
// R14 - Counter top bit rising raises interrupt and sets cause pending bit.
// R15 - Kernel qualifier at privilege 0, supervisor at 1, both levels clear.
// R16 - Reset loads control 0 with c0000000 and control 1 with 40000000.
// R17 - Control holds a 4-bit event select; count only when a qualifier matches.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
module cpec_core
  import cpec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  privilege_mode_field,
  input  wire logic        exception_level_bit,
  input  wire logic        error_level_bit,
  input  wire logic        branch_valid,
  input  wire logic        jr_valid,
  input  wire logic        jr31_valid,
  input  wire logic        bht_predict,
  input  wire logic        imiss_req_valid,
  input  wire logic        imiss_req_allow,
  input  wire logic        issue_alu0_valid,
  input  wire logic        issue_alu1_valid,
  input  wire logic        issue_mem_valid,
  input  wire logic        issue_falu0_valid,
  input  wire logic        issue_falu1_valid,
  input  wire logic        mem_rd_req_valid,
  input  wire logic        mem_rd_req_allow,
  input  wire logic        mem_wr_req_valid,
  input  wire logic        mem_wr_req_allow,
  input  wire logic        fix_queue_full,
  input  wire logic        reorder_queue_full,
  input  wire logic        cp0_queue_full,
  input  wire logic        fp_queue_full,
  input  wire logic        branch_queue_full,
  input  wire logic        exc_valid,
  input  wire logic [5:0]  exc_code,
  input  wire logic        exc_itlb_probe,
  input  wire logic        commit_valid,
  input  wire logic        branch_mispredict,
  input  wire logic        jr_mispredict,
  input  wire logic        jr31_mispredict,
  input  wire logic        bht_mispredict,
  input  wire logic        dmiss_req_valid,
  input  wire logic        dmiss_req_allow,
  input  wire logic        uncached_valid,
  input  wire logic        uncached_allow,
  input  wire logic        load_spec_miss,
  input  wire logic        cp0_fwd_valid,
  output logic             perf_irq,
  output logic             perf_pending
);
  import cpec_pkg::*;

  logic [31:0] ctrl0_reg;
  logic [31:0] ctrl1_reg;
  logic [15:0] ev0;
  logic [15:0] ev1;
  logic        qual0;
  logic        qual1;
  logic        cnt_en0;
  logic        cnt_en1;
  logic [63:0] cnt0;
  logic [63:0] cnt1;
  logic        ovf0;
  logic        ovf1;
  logic [1:0]  irq_stat_reg;
  logic [1:0]  irq_stat_next;
  logic [1:0]  irq_mask_reg;
  logic        pending_reg;
  logic        irq_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [5:0]  wr_addr_reg;
  logic [31:0] wr_data_reg;
  logic [3:0]  wr_strb_reg;
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        do_write;
  logic        wr_ctrl0;
  logic        wr_ctrl1;
  logic        wr_c0_lo;
  logic        wr_c0_hi;
  logic        wr_c1_lo;
  logic        wr_c1_hi;
  logic        wr_stat;
  logic        wr_mask;
  logic        wr_bad;
  logic [31:0] rd_data;
  logic        rd_bad;
  logic [31:0] wr_bits;

  // Counter 0 event vector
  always_comb
  begin
    ev0 = 16'h0;
    // R02 cycles and branches
    ev0[EV_CODE_0] = 1'b1;
    ev0[EV_CODE_1] = branch_valid;
    ev0[EV_CODE_2] = jr_valid;
    ev0[EV_CODE_3] = jr31_valid;
    ev0[EV_CODE_8] = bht_predict;
    // R03 misses and reads
    ev0[EV_CODE_4] = imiss_req_valid && imiss_req_allow;
    ev0[EV_CODE_9] = mem_rd_req_valid && mem_rd_req_allow;
    // R04 issue per unit
    ev0[EV_CODE_5] = issue_alu0_valid;
    ev0[EV_CODE_6] = issue_mem_valid;
    ev0[EV_CODE_7] = issue_falu0_valid;
    // R05 queue full
    ev0[EV_CODE_A] = fix_queue_full;
    ev0[EV_CODE_B] = reorder_queue_full;
    ev0[EV_CODE_C] = cp0_queue_full;
    // R06 exception types
    ev0[EV_CODE_D] = exc_valid && (exc_code == EXC_CODE_TLBR_A || exc_code == EXC_CODE_TLBR_B);
    ev0[EV_CODE_E] = exc_valid && exc_code == EXC_CODE_INT;
    ev0[EV_CODE_F] = exc_valid && exc_code == EXC_CODE_INTERN;
  end

  // Counter 1 event vector
  always_comb
  begin
    ev1 = 16'h0;
    // R07 commits and mispredicts
    ev1[EV_CODE_0] = commit_valid;
    ev1[EV_CODE_1] = branch_mispredict;
    ev1[EV_CODE_2] = jr_mispredict;
    ev1[EV_CODE_3] = jr31_mispredict;
    ev1[EV_CODE_8] = bht_mispredict;
    // R08 misses and memory
    ev1[EV_CODE_4] = dmiss_req_valid && dmiss_req_allow;
    ev1[EV_CODE_7] = uncached_valid && uncached_allow;
    ev1[EV_CODE_9] = mem_wr_req_valid && mem_wr_req_allow;
    // R09 second units
    ev1[EV_CODE_5] = issue_alu1_valid;
    ev1[EV_CODE_6] = issue_falu1_valid;
    // R10 queue full
    ev1[EV_CODE_A] = fp_queue_full;
    ev1[EV_CODE_B] = branch_queue_full;
    // R11 tlb and exceptions
    ev1[EV_CODE_C] = exc_valid && exc_itlb_probe;
    ev1[EV_CODE_D] = exc_valid;
    // R12 speculation and forwarding
    ev1[EV_CODE_E] = load_spec_miss;
    ev1[EV_CODE_F] = cp0_fwd_valid;
  end

  cpec_count_gate u_gate0 (
    .events               (ev0),
    .event_sel            (ctrl0_reg[CTL_EVT_LSB +: CTL_EVT_W]),
    .qual_en              (ctrl0_reg[3:0]),
    .privilege_mode_field (privilege_mode_field),
    .exception_level_bit  (exception_level_bit),
    .error_level_bit      (error_level_bit),
    .qual_match           (qual0),
    .count_en             (cnt_en0)
  );

  cpec_count_gate u_gate1 (
    .events               (ev1),
    .event_sel            (ctrl1_reg[CTL_EVT_LSB +: CTL_EVT_W]),
    .qual_en              (ctrl1_reg[3:0]),
    .privilege_mode_field (privilege_mode_field),
    .exception_level_bit  (exception_level_bit),
    .error_level_bit      (error_level_bit),
    .qual_match           (qual1),
    .count_en             (cnt_en1)
  );

  cpec_counter64 u_cnt0 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .count_en     (cnt_en0),
    .wr_lo        (wr_c0_lo),
    .wr_hi        (wr_c0_hi),
    .wdata        (wr_data_reg),
    .wstrb        (wr_strb_reg),
    .count_reg    (cnt0),
    .overflow_reg (ovf0)
  );

  cpec_counter64 u_cnt1 (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .count_en     (cnt_en1),
    .wr_lo        (wr_c1_lo),
    .wr_hi        (wr_c1_hi),
    .wdata        (wr_data_reg),
    .wstrb        (wr_strb_reg),
    .count_reg    (cnt1),
    .overflow_reg (ovf1)
  );

  // Write address decode
  always_comb
  begin
    do_write = aw_full_reg && w_full_reg && !bvalid_reg;
    wr_ctrl0 = 1'b0;
    wr_ctrl1 = 1'b0;
    wr_c0_lo = 1'b0;
    wr_c0_hi = 1'b0;
    wr_c1_lo = 1'b0;
    wr_c1_hi = 1'b0;
    wr_stat  = 1'b0;
    wr_mask  = 1'b0;
    wr_bad   = 1'b0;
    if (wr_addr_reg == OFF_CTRL0)
      wr_ctrl0 = do_write;
    else if (wr_addr_reg == OFF_CTRL1)
      wr_ctrl1 = do_write;
    else if (wr_addr_reg == OFF_CNT0_LO)
      wr_c0_lo = do_write;
    else if (wr_addr_reg == OFF_CNT0_HI)
      wr_c0_hi = do_write;
    else if (wr_addr_reg == OFF_CNT1_LO)
      wr_c1_lo = do_write;
    else if (wr_addr_reg == OFF_CNT1_HI)
      wr_c1_hi = do_write;
    else if (wr_addr_reg == OFF_IRQ_STAT)
      wr_stat = do_write;
    else if (wr_addr_reg == OFF_IRQ_MASK)
      wr_mask = do_write;
    else if (wr_addr_reg != OFF_CAUSE)
      wr_bad = 1'b1;
  end

  // Control registers
  always_ff @(posedge aclk)
  begin
    // R16 reset values
    if (!aresetn)
    begin
      ctrl0_reg <= CTRL0_RST;
      ctrl1_reg <= CTRL1_RST;
    end
    else
    begin
      // R17 event select writable
      if (wr_ctrl0)
        ctrl0_reg <= (cpec_merge(ctrl0_reg, wr_data_reg, wr_strb_reg) & CTRL_RW_MASK) | CTRL0_RST;
      if (wr_ctrl1)
        ctrl1_reg <= (cpec_merge(ctrl1_reg, wr_data_reg, wr_strb_reg) & CTRL_RW_MASK) | CTRL1_RST;
    end
  end

  // Sticky status, set wins over clear
  always_comb
  begin
    wr_bits       = cpec_merge(32'h0, wr_data_reg, wr_strb_reg);
    irq_stat_next = irq_stat_reg;
    if (wr_stat)
      irq_stat_next = irq_stat_reg & ~wr_bits[1:0];
    irq_stat_next = irq_stat_next | {ovf1, ovf0};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_reg <= 2'h0;
      irq_mask_reg <= IRQ_MASK_RST;
      irq_reg      <= 1'b0;
      pending_reg  <= 1'b0;
    end
    else
    begin
      // R14 overflow interrupt
      irq_stat_reg <= irq_stat_next;
      if (wr_mask)
        irq_mask_reg <= wr_bits[1:0];
      irq_reg     <= |(irq_stat_reg & irq_mask_reg);
      pending_reg <= |irq_stat_reg;
    end
  end

  // Write channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      wr_addr_reg <= 6'h0;
      wr_data_reg <= 32'h0;
      wr_strb_reg <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        wr_addr_reg <= {s_axi_awaddr[5:2], 2'b00};
      end
      if (s_axi_wvalid && wready_reg)
      begin
        w_full_reg  <= 1'b1;
        wready_reg  <= 1'b0;
        wr_data_reg <= s_axi_wdata;
        wr_strb_reg <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_bad ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_reg && s_axi_bready)
      begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read decode
  always_comb
  begin
    rd_data = 32'h0;
    rd_bad  = 1'b0;
    if (s_axi_araddr[5:2] == OFF_CTRL0[5:2])
      rd_data = ctrl0_reg;
    else if (s_axi_araddr[5:2] == OFF_CTRL1[5:2])
      rd_data = ctrl1_reg;
    // R13 readable counters
    else if (s_axi_araddr[5:2] == OFF_CNT0_LO[5:2])
      rd_data = cnt0[31:0];
    else if (s_axi_araddr[5:2] == OFF_CNT0_HI[5:2])
      rd_data = cnt0[63:32];
    else if (s_axi_araddr[5:2] == OFF_CNT1_LO[5:2])
      rd_data = cnt1[31:0];
    else if (s_axi_araddr[5:2] == OFF_CNT1_HI[5:2])
      rd_data = cnt1[63:32];
    else if (s_axi_araddr[5:2] == OFF_IRQ_STAT[5:2])
      rd_data = {30'h0, irq_stat_reg};
    else if (s_axi_araddr[5:2] == OFF_IRQ_MASK[5:2])
      rd_data = {30'h0, irq_mask_reg};
    // R14 cause pending bit
    else if (s_axi_araddr[5:2] == OFF_CAUSE[5:2])
      rd_data[CAUSE_PCI_BIT] = pending_reg;
    else
      rd_bad = 1'b1;
  end

  // Read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_data;
      rresp_reg   <= rd_bad ? RESP_SLVERR : RESP_OKAY;
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign perf_irq      = irq_reg;
  assign perf_pending  = pending_reg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_user_qual;
    ctrl0_reg[CTL_U_BIT] && privilege_mode_field == PRIV_USER && !exception_level_bit && !error_level_bit
      |-> qual0;
  endproperty
  a_user_qual: assert property (p_user_qual) else $error("user qualifier missed"); // R01

  property p_err_blocks;
    error_level_bit |-> !qual0 && !qual1;
  endproperty
  a_err_blocks: assert property (p_err_blocks) else $error("counting at error level"); // R01

  property p_kern_qual;
    ctrl1_reg[CTL_K_BIT] && privilege_mode_field == PRIV_KERNEL && !exception_level_bit && !error_level_bit
      |-> qual1;
  endproperty
  a_kern_qual: assert property (p_kern_qual) else $error("kernel qualifier missed"); // R15

  property p_cycles;
    ctrl0_reg[CTL_EVT_LSB +: CTL_EVT_W] == EV_CODE_0 && qual0 && !wr_c0_lo && !wr_c0_hi
      |=> cnt0 == $past(cnt0) + 64'h1;
  endproperty
  a_cycles: assert property (p_cycles) else $error("cycle count not advanced"); // R02

  property p_tlb_refill;
    ctrl0_reg[CTL_EVT_LSB +: CTL_EVT_W] == EV_CODE_D && qual0 && exc_valid && exc_code == EXC_CODE_TLBR_B
      |-> cnt_en0;
  endproperty
  a_tlb_refill: assert property (p_tlb_refill) else $error("refill exception not counted"); // R06

  property p_any_exc;
    ctrl1_reg[CTL_EVT_LSB +: CTL_EVT_W] == EV_CODE_D && qual1 && exc_valid |-> cnt_en1;
  endproperty
  a_any_exc: assert property (p_any_exc) else $error("exception not counted"); // R11

  property p_hold;
    !cnt_en1 && !wr_c1_lo && !wr_c1_hi |=> $stable(cnt1);
  endproperty
  a_hold: assert property (p_hold) else $error("counter moved without event"); // R17

  property p_overflow;
    !cnt0[63] ##1 cnt0[63] |=> irq_stat_reg[0] ##1 pending_reg;
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow not flagged"); // R14

  property p_irq;
    |(irq_stat_reg & irq_mask_reg) |=> perf_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised"); // R14

  property p_reset;
    disable iff (1'b0) !aresetn |=> ctrl0_reg == CTRL0_RST && ctrl1_reg == CTRL1_RST;
  endproperty
  a_reset: assert property (p_reset) else $error("control reset value wrong"); // R16

  c_write: cover property (do_write ##1 s_axi_bvalid);
  c_read: cover property (s_axi_arvalid && s_axi_arready ##1 s_axi_rvalid);
  c_ovf: cover property (ovf1);

endmodule

// File: logic/cpec_count_gate.sv
module cpec_count_gate
  import cpec_pkg::*;
(
  input  wire logic [15:0] events,
  input  wire logic [3:0]  event_sel,
  input  wire logic [3:0]  qual_en,
  input  wire logic [1:0]  privilege_mode_field,
  input  wire logic        exception_level_bit,
  input  wire logic        error_level_bit,
  output logic             qual_match,
  output logic             count_en
);
  import cpec_pkg::*;

  logic normal_lvl;

  always_comb
  begin
    normal_lvl = !exception_level_bit && !error_level_bit;
    qual_match = 1'b0;
    // R15 kernel and supervisor
    if (qual_en[CTL_K_BIT] && normal_lvl && privilege_mode_field == PRIV_KERNEL)
      qual_match = 1'b1;
    if (qual_en[CTL_S_BIT] && normal_lvl && privilege_mode_field == PRIV_SUPER)
      qual_match = 1'b1;
    // R01 user and exception level
    if (qual_en[CTL_U_BIT] && normal_lvl && privilege_mode_field == PRIV_USER)
      qual_match = 1'b1;
    if (qual_en[CTL_EXL_BIT] && exception_level_bit && !error_level_bit)
      qual_match = 1'b1;
    // R17 select event, gate by qualifier
    count_en = qual_match && events[event_sel];
  end

endmodule

// File: logic/cpec_counter64.sv
module cpec_counter64
  import cpec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        count_en,
  input  wire logic        wr_lo,
  input  wire logic        wr_hi,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic [63:0]      count_reg,
  output logic             overflow_reg
);
  import cpec_pkg::*;

  logic [63:0] count_next;

  always_comb
  begin
    count_next = count_reg;
    // R13 increment by one
    if (count_en)
      count_next = count_reg + 64'h1;
    if (wr_lo)
      count_next[31:0] = cpec_merge(count_reg[31:0], wdata, wstrb);
    if (wr_hi)
      count_next[63:32] = cpec_merge(count_reg[63:32], wdata, wstrb);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_reg    <= 64'h0;
      overflow_reg <= 1'b0;
    end
    else
    begin
      count_reg    <= count_next;
      // R14 top bit rises
      overflow_reg <= !count_reg[63] && count_next[63];
    end
  end

endmodule

// File: logic/cpec_pkg.sv
package cpec_pkg;

  localparam int unsigned CPEC_ADDR_W = 6;
  localparam int unsigned CPEC_DATA_W = 32;

  localparam logic [5:0] OFF_CTRL0    = 6'h00;
  localparam logic [5:0] OFF_CNT0_LO  = 6'h04;
  localparam logic [5:0] OFF_CNT0_HI  = 6'h08;
  localparam logic [5:0] OFF_CTRL1    = 6'h0c;
  localparam logic [5:0] OFF_CNT1_LO  = 6'h10;
  localparam logic [5:0] OFF_CNT1_HI  = 6'h14;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h18;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h1c;
  localparam logic [5:0] OFF_CAUSE    = 6'h20;

  localparam int unsigned CTL_EXL_BIT = 0;
  localparam int unsigned CTL_K_BIT   = 1;
  localparam int unsigned CTL_S_BIT   = 2;
  localparam int unsigned CTL_U_BIT   = 3;
  localparam int unsigned CTL_EVT_LSB = 5;
  localparam int unsigned CTL_EVT_W   = 4;
  localparam int unsigned CAUSE_PCI_BIT = 0;

  localparam logic [31:0] CTRL0_RST    = 32'hc000_0000;
  localparam logic [31:0] CTRL1_RST    = 32'h4000_0000;
  localparam logic [31:0] CTRL_RW_MASK = 32'h0000_01ef;
  localparam logic [1:0]  IRQ_MASK_RST = 2'h0;

  localparam logic [1:0] PRIV_KERNEL = 2'h0;
  localparam logic [1:0] PRIV_SUPER  = 2'h1;
  localparam logic [1:0] PRIV_USER   = 2'h2;

  localparam logic [5:0] EXC_CODE_INT    = 6'h00;
  localparam logic [5:0] EXC_CODE_TLBR_A = 6'h22;
  localparam logic [5:0] EXC_CODE_TLBR_B = 6'h23;
  localparam logic [5:0] EXC_CODE_INTERN = 6'h3f;

  localparam logic [3:0] EV_CODE_0 = 4'h0;
  localparam logic [3:0] EV_CODE_1 = 4'h1;
  localparam logic [3:0] EV_CODE_2 = 4'h2;
  localparam logic [3:0] EV_CODE_3 = 4'h3;
  localparam logic [3:0] EV_CODE_4 = 4'h4;
  localparam logic [3:0] EV_CODE_5 = 4'h5;
  localparam logic [3:0] EV_CODE_6 = 4'h6;
  localparam logic [3:0] EV_CODE_7 = 4'h7;
  localparam logic [3:0] EV_CODE_8 = 4'h8;
  localparam logic [3:0] EV_CODE_9 = 4'h9;
  localparam logic [3:0] EV_CODE_A = 4'ha;
  localparam logic [3:0] EV_CODE_B = 4'hb;
  localparam logic [3:0] EV_CODE_C = 4'hc;
  localparam logic [3:0] EV_CODE_D = 4'hd;
  localparam logic [3:0] EV_CODE_E = 4'he;
  localparam logic [3:0] EV_CODE_F = 4'hf;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a write into an old word
  function automatic logic [31:0] cpec_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[i*8 +: 8] = new_val[i*8 +: 8];
    end
    return res;
  endfunction

endpackage

// File: verif/core_perf_event_counters_tb.sv
module core_perf_event_counters_tb
  import cpec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  s_axi_awaddr = '0, s_axi_araddr = '0, exc_code = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp, privilege_mode_field = '0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, perf_irq, perf_pending;
  logic        exception_level_bit = 0, error_level_bit = 0;
  logic [32:0] ev, ev_set = '0;
  int          err_total = 0, n_tests = 0;
  int          m0[16] = '{0, 0, 2, 4, 9, 12, 16, 18, 6, 23, 30, 32, 34, 40, 40, 40};
  int          m1[16] = '{44, 46, 48, 50, 55, 14, 20, 59, 52, 27, 36, 38, 41, 40, 62, 64};

  cpec_core dut (.*,
    .branch_valid(ev[0]), .jr_valid(ev[1]), .jr31_valid(ev[2]), .bht_predict(ev[3]),
    .imiss_req_valid(ev[4]), .imiss_req_allow(ev[5]), .issue_alu0_valid(ev[6]), .issue_alu1_valid(ev[7]),
    .issue_mem_valid(ev[8]), .issue_falu0_valid(ev[9]), .issue_falu1_valid(ev[10]),
    .mem_rd_req_valid(ev[11]), .mem_rd_req_allow(ev[12]), .mem_wr_req_valid(ev[13]), .mem_wr_req_allow(ev[14]),
    .fix_queue_full(ev[15]), .reorder_queue_full(ev[16]), .cp0_queue_full(ev[17]), .fp_queue_full(ev[18]),
    .branch_queue_full(ev[19]), .exc_valid(ev[20]), .exc_itlb_probe(ev[21]), .commit_valid(ev[22]),
    .branch_mispredict(ev[23]), .jr_mispredict(ev[24]), .jr31_mispredict(ev[25]), .bht_mispredict(ev[26]),
    .dmiss_req_valid(ev[27]), .dmiss_req_allow(ev[28]), .uncached_valid(ev[29]), .uncached_allow(ev[30]),
    .load_spec_miss(ev[31]), .cp0_fwd_valid(ev[32]));

  cpec_pipe_model pm (.aclk(aclk), .aresetn(aresetn), .ev_set(ev_set), .ev(ev));

  initial
  begin
    forever #20 aclk = ~aclk;
  end

  task automatic end_sim();
    $display("Checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk_f(input string nm, input logic [1:0] e, input logic [1:0] g);
    chk(nm, {30'h0, e}, {30'h0, g});
  endtask

  function automatic bit qm(int q, logic [1:0] p, bit x, bit r);
    return q == 0 ? x && !r : !x && !r && p == q - 1;
  endfunction

  // One register access, held until its response
  task automatic bus(input bit w, input logic [5:0] a, input logic [31:0] d);
    int t;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (t = 0; t < 50; t++)
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if ((w && s_axi_bvalid) || (!w && s_axi_rvalid))
        break;
    end
    rsp = w ? s_axi_bresp : s_axi_rresp;
    rd = s_axi_rdata;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    if (t == 50)
    begin
      err_total++;
      end_sim();
    end
  endtask

  initial
  begin
    int c, k, q, n, v;
    logic [1:0] p;
    bit x, r;
    logic [32:0] e;
    logic [31:0] cw;
    logic [5:0] a;
    void'($urandom(75));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    bus(0, OFF_CTRL0, 0);
    chk("ctrl0 reset", CTRL0_RST, rd);
    bus(0, OFF_CTRL1, 0);
    chk("ctrl1 reset", CTRL1_RST, rd);
    bus(0, OFF_IRQ_MASK, 0);
    chk("mask reset", 32'h0, rd);
    // Every event code of both counters under random qualifiers
    for (int i = 1; i < 64; i++)
    begin
      c = i / 16 % 2;
      k = i % 16;
      q = $urandom_range(3);
      n = $urandom_range(6, 1);
      v = c ? m1[k] : m0[k];
      e = 33'h1 << (v / 2);
      if (v % 2)
        e = e | (e << 1);
      p = $urandom_range(1) ? 2'(q - 1) : 2'($urandom);
      x = $urandom % 3 == 0;
      r = $urandom % 6 == 0;
      privilege_mode_field <= p;
      exception_level_bit <= x;
      error_level_bit <= r;
      exc_code <= (c || k < 13) ? 6'($urandom) : k == 13 ? EXC_CODE_TLBR_A + 6'($urandom % 2) :
                  k == 14 ? EXC_CODE_INT : EXC_CODE_INTERN;
      cw = ($urandom & 32'hfffffe10) | (32'h1 << q) | (k << CTL_EVT_LSB);
      a = c ? OFF_CTRL1 : OFF_CTRL0;
      bus(1, a, cw);
      bus(0, a, 0);
      chk("ctrl", (cw & CTRL_RW_MASK) | ((c ? CTRL1_RST : CTRL0_RST) & 32'hc000_0000), rd);
      bus(1, a + 6'h4, 0);
      bus(1, a + 6'h8, 0);
      @(posedge aclk);
      ev_set <= e;
      repeat (n) @(posedge aclk);
      ev_set <= '0;
      repeat (3) @(posedge aclk);
      bus(0, a + 6'h4, 0);
      // Cycle code runs from the low-word clear up to the read: ten bus cycles plus n
      chk("count", qm(q, p, x, r) ? ((c == 0 && k == 0) ? n + 10 : n) : 0, rd);
    end
    // Carry into the top word and overflow interrupt
    privilege_mode_field <= PRIV_KERNEL;
    exception_level_bit <= 1'b0;
    error_level_bit <= 1'b0;
    bus(1, OFF_CTRL0, 32'h22);
    bus(1, OFF_CNT0_LO, 32'hffff_ffff);
    bus(1, OFF_CNT0_HI, 32'h7fff_ffff);
    bus(1, OFF_IRQ_STAT, 32'h3);
    @(posedge aclk);
    ev_set <= 33'h1;
    @(posedge aclk);
    ev_set <= '0;
    repeat (5) @(posedge aclk);
    bus(0, OFF_CNT0_HI, 0);
    chk("count hi", 32'h8000_0000, rd);
    bus(0, OFF_IRQ_STAT, 0);
    chk("status", 32'h1, rd);
    bus(0, OFF_CAUSE, 0);
    chk("cause", 32'h1, rd);
    chk_f("irq masked", 0, perf_irq);
    chk_f("pending", 1, perf_pending);
    bus(1, OFF_IRQ_MASK, 32'h1);
    repeat (3) @(posedge aclk);
    chk_f("irq", 1, perf_irq);
    bus(1, OFF_IRQ_STAT, 32'h1);
    repeat (3) @(posedge aclk);
    chk_f("irq cleared", 0, perf_irq);
    chk_f("pending cleared", 0, perf_pending);
    bus(1, 6'h24, 32'h5a5a_5a5a);
    chk_f("unmapped wr", RESP_SLVERR, rsp);
    bus(0, 6'h24, 0);
    chk_f("unmapped rd", RESP_SLVERR, rsp);
    chk("unmapped data", 32'h0, rd);
    end_sim();
  end
endmodule

// File: verif/cpec_pipe_model.sv
module cpec_pipe_model
  import cpec_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [32:0] ev_set,
  output logic      [32:0] ev
);
  timeunit 1ns;
  timeprecision 1ns;

  // Strobes change just after the edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ev <= 33'h0;
    else
      ev <= ev_set;
  end
endmodule
